/* File: core/ahp_addr_latch.sv */
// Address and chip select latch for the multiplexed bus.
`timescale 1ns/1ps
`default_nettype none
module ahp_addr_latch
  import ahp_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              ale_in,
  input  wire logic              cs_b_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  output var  logic              cs_b_out,
  output var  logic [ADDR_W-1:0] addr_out
);
  logic              held_cs_b;
  logic [ADDR_W-1:0] held_addr;
  logic              next_held_cs_b;
  logic [ADDR_W-1:0] next_held_addr;

  // Held copy tracks the bus while the strobe is high and freezes when it falls.
  always_comb
  begin
    next_held_cs_b = held_cs_b;
    next_held_addr = held_addr;
    if (ale_in)
    begin
      next_held_cs_b = cs_b_in;  // RQ7
      next_held_addr = addr_in;  // RQ7
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      held_cs_b <= 1'b1;
      held_addr <= '0;
    end
    else
    begin
      held_cs_b <= next_held_cs_b;
      held_addr <= next_held_addr;
    end
  end

  // Strobe high passes straight through; low shows the latched pair only.
  always_comb
  begin
    cs_b_out = ale_in ? cs_b_in : held_cs_b;  // RQ8 RQ9
    addr_out = ale_in ? addr_in : held_addr;  // RQ8 RQ9
  end
endmodule // ahp_addr_latch
`default_nettype wire

/* File: core/ahp_host_port.sv */
// Host bus port, conversion sequencer, result FIFO and instruction store.
// -----------------------------------------------------------------------------
// What this block does
// [RQ1] Conversion runs states 0,1 one clock, 7 nine, 5 forty-four, then a store clock.
// [RQ2] Bus width high uses low byte only, upper lines float; low gives 16 bits.
// [RQ3] Data lines driven only while read strobe and chip select are both low.
// [RQ4] Data taken from the bus while store strobe and chip select are low.
// [RQ5] Chip select low freezes the sequencer; it resumes when select rises.
// [RQ6] Host holds chip select low only during real accesses.
// [RQ7] Strobe high passes the address; its falling edge latches address and select.
// [RQ8] While the latch strobe is low, address and select changes are ignored.
// [RQ9] Non-multiplexed hosts hold the latch strobe high permanently.
// [RQ10] Five address lines select registers, the FIFO and instruction store.
// [RQ11] With sync direction low, the sync pin is an input; its rise samples.
// [RQ12] After a sync rise the conversion starts on the next clock edge.
// [RQ13] With sync direction high, sync is driven high during a conversion.
// [RQ14] Reset sets the sync pin as an input.
// [RQ15] Interrupt output low while any unmasked source of eight is pending.
// [RQ16] Reading interrupt status clears all pending bits and releases the output.
// [RQ17] Transfer request high when FIFO count equals a non-zero programmed count.
// [RQ18] The system supplies the device clock within its allowed range.
// [RQ19] The instruction selects single-ended or any-pair differential inputs.
// [RQ20] Eight instructions occupy word indices 0 to 7, bytes 0 to 15.
// [RQ21] Transfer request falls once reads bring the count below the programmed value.
// -----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module ahp_host_port
  import ahp_pkg::*;
(
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_b_in,
  input  wire logic                      cs_b_in,
  input  wire logic                      rd_b_in,
  input  wire logic                      wr_b_in,
  input  wire logic                      ale_in,
  input  wire logic                      bus_width_select_in,
  input  wire logic [ahp_pkg::ADDR_W-1:0] register_select_lines_in,
  input  wire logic [ahp_pkg::DATA_W-1:0] host_data_lines_in,
  output var  logic [ahp_pkg::DATA_W-1:0] host_data_lines_out,
  output var  logic [ahp_pkg::DATA_W-1:0] host_data_lines_oe_out,
  input  wire logic                      sync_in,
  output var  logic                      sync_out,
  output var  logic                      sync_oe_out,
  input  wire logic [12:0]               conv_result_in,
  input  wire logic [3:0]                aux_irq_in,
  output var  logic [2:0]                mux_pos_out,
  output var  logic [2:0]                mux_neg_out,
  output var  logic                      mux_diff_out,
  output var  logic                      int_b_out,
  output var  logic                      transfer_request_out
);
  // ---------------------------------------------------------------------------
  // Pin synchronisers and address latch
  // ---------------------------------------------------------------------------
  logic              cs_b_s, rd_b_s, wr_b_s, ale_s, bw_s, sync_s, sync_d;
  logic [ADDR_W-1:0] addr_s, addr_eff;
  logic [DATA_W-1:0] data_s;
  logic              cs_b_eff;

  ahp_sync2 #(.W(ADDR_W + DATA_W + 6)) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .d_in       ({cs_b_in, rd_b_in, wr_b_in, ale_in, bus_width_select_in, sync_in,
                  register_select_lines_in, host_data_lines_in}),
    .q_out      ({cs_b_s, rd_b_s, wr_b_s, ale_s, bw_s, sync_s, addr_s, data_s})
  );

  ahp_addr_latch u_latch (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .ale_in     (ale_s),
    .cs_b_in    (cs_b_s),
    .addr_in    (addr_s),
    .cs_b_out   (cs_b_eff),
    .addr_out   (addr_eff)
  );

  // ---------------------------------------------------------------------------
  // State declarations
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] cfg, ien, next_cfg, next_ien;
  logic [N_IRQ-1:0]  ist, next_ist, irq_src;
  logic              rd_act, wr_act, rd_act_d, wr_act_d, next_rd_act_d, next_wr_act_d;
  logic [ADDR_W-1:0] acc_addr, next_acc_addr;
  logic [DATA_W-1:0] wlat, next_wlat, rdata, next_dout, next_oe, merged;
  logic              rd_end, wr_end, ist_clear, fifo_pop, ram_we, freeze, soft_rst;
  logic              next_int_b, next_dma;
  logic [DATA_W-1:0] ram [N_INSTR][N_SECT];
  logic [DATA_W-1:0] fifo_mem [FIFO_DEPTH];
  ahp_seq_e          state, next_state;
  logic [5:0]        cnt, next_cnt, fifo_cnt, next_fifo_cnt;
  logic [4:0]        wp, rp, next_wp, next_rp;
  logic [2:0]        pc, next_pc;
  logic              next_sync, fifo_push, sync_rise, start_ok;
  logic [DATA_W-1:0] instr;
  logic [3:0]        aidx;
  logic [1:0]        ptr;

  // Strobes qualified by chip select, and the word index of the access.
  always_comb
  begin
    rd_act    = !cs_b_eff && !rd_b_s;       // RQ3
    wr_act    = !cs_b_eff && !wr_b_s;       // RQ4
    rd_end    = rd_act_d && !rd_act;
    wr_end    = wr_act_d && !wr_act;
    aidx      = (rd_act || wr_act) ? addr_eff[ADDR_W-1:1] : acc_addr[ADDR_W-1:1];  // RQ10 RQ20
    ptr       = cfg[CFG_PTR_LO +: 2];
    freeze    = !cs_b_s;                    // RQ5 RQ6
    sync_rise = sync_s && !sync_d;          // RQ11
    ist_clear = rd_end && (aidx == IDX_IST);
    fifo_pop  = rd_end && (aidx == IDX_FIFO) && (fifo_cnt != 6'h00);
    ram_we    = wr_end && (aidx <= RAM_TOP) && (ptr != 2'b11);
  end

  // ---------------------------------------------------------------------------
  // Read path: data mux and output drivers
  // ---------------------------------------------------------------------------
  always_comb
  begin
    rdata = '0;
    if (aidx <= RAM_TOP)
    begin
      rdata = (ptr == 2'b11) ? '0 : ram[aidx[2:0]][ptr];  // RQ10 RQ20
    end
    else
    begin
      unique case (aidx)
        IDX_CFG:  rdata = cfg;
        IDX_IEN:  rdata = ien;
        IDX_IST:  rdata = {{(DATA_W - N_IRQ){1'b0}}, ist};
        IDX_FIFO: rdata = fifo_mem[rp];
        default:  rdata = '0;
      endcase
    end
    next_dout = bw_s ? {8'h00, ((rd_act ? addr_eff[0] : acc_addr[0]) ? rdata[15:8] : rdata[7:0])} : rdata;  // RQ2
    next_oe   = rd_act ? (bw_s ? OE_BYTE : OE_WORD) : '0;                           // RQ2 RQ3
  end

  // ---------------------------------------------------------------------------
  // Write path and register file next values
  // ---------------------------------------------------------------------------
  always_comb
  begin
    next_rd_act_d = rd_act;
    next_wr_act_d = wr_act;
    next_acc_addr = (rd_act || wr_act) ? addr_eff : acc_addr;
    next_wlat     = wr_act ? data_s : wlat;                  // RQ4
    merged        = rdata;
    if (bw_s)
    begin
      if (acc_addr[0])
        merged[15:8] = wlat[7:0];
      else
        merged[7:0] = wlat[7:0];
    end
    else
    begin
      merged = wlat;
    end
    soft_rst = wr_end && (aidx == IDX_CFG) && merged[CFG_SOFTRST];
    next_cfg = cfg;
    next_ien = ien;
    if (wr_end && aidx == IDX_CFG)
      next_cfg = merged;                                     // RQ4
    if (wr_end && aidx == IDX_IEN)
      next_ien = merged;
    if (soft_rst)
      next_cfg[CFG_SOFTRST] = 1'b0;                          // Soft reset bit self-clears.
    // Sources win over a clear in the same cycle.
    next_ist   = (ist_clear ? '0 : ist) | irq_src;           // RQ16
    next_int_b = ~|(ist & ien[N_IRQ-1:0]);                   // RQ15
    next_dma   = (ien[IEN_CNT_LO +: 5] != 5'h00) &&
                 (fifo_cnt == {1'b0, ien[IEN_CNT_LO +: 5]});  // RQ17 RQ21
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cfg                    <= CFG_RESET;                   // RQ14
      ien                    <= IEN_RESET;
      ist                    <= '0;
      rd_act_d               <= 1'b0;
      wr_act_d               <= 1'b0;
      acc_addr               <= '0;
      wlat                   <= '0;
      host_data_lines_out    <= '0;
      host_data_lines_oe_out <= '0;
      int_b_out              <= 1'b1;
      transfer_request_out   <= 1'b0;
    end
    else
    begin
      cfg                    <= next_cfg;
      ien                    <= next_ien;
      ist                    <= next_ist;
      rd_act_d               <= next_rd_act_d;
      wr_act_d               <= next_wr_act_d;
      acc_addr               <= next_acc_addr;
      wlat                   <= next_wlat;
      host_data_lines_out    <= next_dout;
      host_data_lines_oe_out <= next_oe;
      int_b_out              <= next_int_b;
      transfer_request_out   <= next_dma;
    end
  end

  // Instruction store, one word per section, written when a store strobe ends; result FIFO written on a push.
  always_ff @(posedge ref_clk_in)
  begin
    if (ram_we)
      ram[aidx[2:0]][ptr] <= merged;                         // RQ20
    if (fifo_push)
      fifo_mem[wp] <= {{3{conv_result_in[12]}}, conv_result_in};
  end

  // ---------------------------------------------------------------------------
  // Conversion sequencer and FIFO pointers
  // ---------------------------------------------------------------------------
  always_comb
  begin
    instr         = ram[pc][0];
    start_ok      = cfg[CFG_START] && (cfg[CFG_SYNCDIR] || sync_rise);  // RQ11 RQ12
    next_state    = state;
    next_cnt      = cnt;
    next_pc       = pc;
    fifo_push     = 1'b0;
    irq_src       = {aux_irq_in, 4'h0};
    next_wp       = wp;
    next_rp       = fifo_pop ? rp + 5'd1 : rp;
    next_fifo_cnt = fifo_pop ? fifo_cnt - 6'd1 : fifo_cnt;              // RQ21
    if (!freeze)
    begin
      unique case (state)
        AHP_IDLE:  if (start_ok) next_state = AHP_ST0;                  // RQ12
        AHP_ST0:   next_state = AHP_ST1;                                // RQ1
        AHP_ST1:
        begin
          next_state = AHP_ST7;
          next_cnt   = ST7_CYCLES - 6'd1;
        end
        AHP_ST7:
        begin
          next_cnt = cnt - 6'd1;
          if (cnt == 6'd0)
          begin
            next_state = AHP_ST5;
            next_cnt   = ST5_CYCLES - 6'd1;                             // RQ1
          end
        end
        AHP_ST5:
        begin
          next_cnt = cnt - 6'd1;
          if (cnt == 6'd0)
            next_state = AHP_STORE;
        end
        AHP_STORE:
        begin
          next_pc             = pc + 3'd1;
          irq_src[IRQ_DONE]   = 1'b1;
          fifo_push           = (fifo_cnt != 6'(FIFO_DEPTH));
          irq_src[IRQ_OVER]   = !fifo_push;
          next_state          = (cfg[CFG_START] && cfg[CFG_SYNCDIR]) ? AHP_ST0 : AHP_IDLE;
        end
        default:   next_state = AHP_IDLE;
      endcase
    end
    if (fifo_push)
    begin
      next_wp       = wp + 5'd1;
      next_fifo_cnt = next_fifo_cnt + 6'd1;
      irq_src[IRQ_FULL]  = (next_fifo_cnt == 6'(FIFO_DEPTH));
      irq_src[IRQ_COUNT] = (next_fifo_cnt == {1'b0, ien[IEN_CNT_LO +: 5]});
    end
    if (soft_rst)
    begin
      next_state    = AHP_IDLE;
      next_pc       = 3'd0;
      next_wp       = 5'd0;
      next_rp       = 5'd0;
      next_fifo_cnt = 6'd0;
    end
    next_sync = (next_state != AHP_IDLE) && (next_state != AHP_STORE);  // RQ13
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state        <= AHP_IDLE;
      cnt          <= '0;
      pc           <= '0;
      wp           <= '0;
      rp           <= '0;
      fifo_cnt     <= '0;
      sync_d       <= 1'b0;
      sync_out     <= 1'b0;
      sync_oe_out  <= 1'b0;                                             // RQ14
      mux_pos_out  <= '0;
      mux_neg_out  <= '0;
      mux_diff_out <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      cnt          <= next_cnt;
      pc           <= next_pc;
      wp           <= next_wp;
      rp           <= next_rp;
      fifo_cnt     <= next_fifo_cnt;
      sync_d       <= sync_s;
      sync_out     <= next_sync;                                        // RQ13
      sync_oe_out  <= cfg[CFG_SYNCDIR];                                 // RQ11 RQ13
      mux_pos_out  <= instr[INS_POS_LO +: 3];                           // RQ19
      mux_neg_out  <= instr[INS_NEG_LO +: 3];                           // RQ19
      mux_diff_out <= instr[INS_DIFF];                                  // RQ19
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions and covers
  // ---------------------------------------------------------------------------
  logic [6:0] busy_cnt;
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      busy_cnt <= '0;
    else if (next_state == AHP_ST0 && state != AHP_ST0)
      busy_cnt <= '0;
    else if (!freeze && state != AHP_IDLE && state != AHP_STORE)
      busy_cnt <= busy_cnt + 7'd1;
  end

  default clocking dcb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  conv_length_a: assert property ($rose(state == AHP_STORE) |-> busy_cnt == BUSY_CYCLES) // RQ1
    else $error("Conversion did not last the documented cycles.");
  upper_float_a: assert property (rd_act && bw_s |=> host_data_lines_oe_out == OE_BYTE) // RQ2
    else $error("Byte mode drove the upper data lines.");
  read_drive_a: assert property (!rd_act |=> host_data_lines_oe_out == '0) // RQ3
    else $error("Data driven without an active read.");
  write_cfg_a: assert property (wr_end && aidx == IDX_CFG && !bw_s && !wlat[CFG_SOFTRST]
    |=> cfg == $past(wlat)) // RQ4
    else $error("Configuration write lost.");
  freeze_hold_a: assert property (freeze && state != AHP_IDLE && !soft_rst |=> $stable(state) && $stable(cnt)) // RQ5
    else $error("Sequencer advanced while select was low.");
  ale_hold_a: assert property (!ale_s && !$past(ale_s) |-> $stable(addr_eff) && $stable(cs_b_eff)) // RQ8
    else $error("Latched address moved while strobe was low.");
  sync_start_a: assert property (state == AHP_IDLE && start_ok && !freeze && !soft_rst
    |=> state == AHP_ST0 ##1 sync_out) // RQ12
    else $error("Sync edge did not start a conversion.");
  sync_drive_a: assert property (state == AHP_ST5 && sync_oe_out |-> sync_out) // RQ13
    else $error("Sync output low during a conversion.");
  int_assert_a: assert property (|(ist & ien[N_IRQ-1:0]) |=> !int_b_out) // RQ15
    else $error("Unmasked source did not raise the interrupt.");
  int_clear_a: assert property (ist_clear && irq_src == '0 |=> ist == '0 ##1 int_b_out) // RQ16
    else $error("Status read did not release the interrupt.");
  dma_match_a: assert property (ien[IEN_CNT_LO +: 5] != 5'h00 && fifo_cnt == {1'b0, ien[IEN_CNT_LO +: 5]}
    |=> transfer_request_out) // RQ17
    else $error("Transfer request missing on count match.");

  conv_done_c: cover property (state == AHP_STORE);
  byte_read_c: cover property (rd_act && bw_s);
  frozen_c:    cover property (freeze && state == AHP_ST5);
  dma_c:       cover property ($rose(transfer_request_out));
endmodule // ahp_host_port
`default_nettype wire

/* File: core/ahp_pkg.sv */
// Shared constants for the acquisition host bus port.
package ahp_pkg;
  // ---------------------------------------------------------------------------
  // Bus widths and address decode
  // ---------------------------------------------------------------------------
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned ADDR_W    = 5;
  localparam int unsigned BYTE_W    = 8;
  localparam logic [3:0]  RAM_TOP   = 4'h7;   // Word indices 0 to 7 hold instructions.
  localparam logic [3:0]  IDX_CFG   = 4'h8;
  localparam logic [3:0]  IDX_IEN   = 4'h9;
  localparam logic [3:0]  IDX_IST   = 4'ha;
  localparam logic [3:0]  IDX_FIFO  = 4'hf;
  localparam logic [15:0] OE_BYTE   = 16'h00ff;
  localparam logic [15:0] OE_WORD   = 16'hffff;

  // ---------------------------------------------------------------------------
  // Configuration and interrupt enable field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned CFG_START   = 0;
  localparam int unsigned CFG_SOFTRST = 1;
  localparam int unsigned CFG_SYNCDIR = 7;
  localparam int unsigned CFG_PTR_LO  = 8;
  localparam int unsigned IEN_CNT_LO  = 11;
  localparam logic [15:0] CFG_RESET   = 16'h0000;
  localparam logic [15:0] IEN_RESET   = 16'h0000;
  localparam int unsigned N_IRQ       = 8;
  localparam int unsigned IRQ_DONE    = 0;
  localparam int unsigned IRQ_FULL    = 1;
  localparam int unsigned IRQ_COUNT   = 2;
  localparam int unsigned IRQ_OVER    = 3;

  // ---------------------------------------------------------------------------
  // Instruction fields and sequencer timing in clock cycles
  // ---------------------------------------------------------------------------
  localparam int unsigned INS_POS_LO  = 2;
  localparam int unsigned INS_NEG_LO  = 5;
  localparam int unsigned INS_DIFF    = 8;
  localparam int unsigned N_INSTR     = 8;
  localparam int unsigned N_SECT      = 3;
  localparam logic [5:0]  ST7_CYCLES  = 6'h09;
  localparam logic [5:0]  ST5_CYCLES  = 6'h2c;
  localparam logic [6:0]  BUSY_CYCLES = 7'h37;  // States 0, 1, 7 and 5 together.
  localparam int unsigned FIFO_DEPTH  = 32;

  typedef enum logic [2:0] {
    AHP_IDLE  = 3'b000,
    AHP_ST0   = 3'b001,
    AHP_ST1   = 3'b010,
    AHP_ST7   = 3'b011,
    AHP_ST5   = 3'b100,
    AHP_STORE = 3'b101
  } ahp_seq_e;
endpackage : ahp_pkg

/* File: core/ahp_sync2.sv */
// Two-flop synchroniser for asynchronous pin levels.
`timescale 1ns/1ps
`default_nettype none
module ahp_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  logic [W-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta  <= '0;
      q_out <= '0;
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule // ahp_sync2
`default_nettype wire

/* File: verification/ahp_host_model.sv */
// Host bus master model that runs read and store cycles on the port pins.
`timescale 1ns/1ps
`default_nettype none
module ahp_host_model
  import ahp_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic [DATA_W-1:0] dq_oe_in,
  output var  logic              cs_b_out,
  output var  logic              rd_b_out,
  output var  logic              wr_b_out,
  output var  logic              ale_out,
  output var  logic [ADDR_W-1:0] addr_out,
  output var  logic [DATA_W-1:0] dq_out
);
  logic [DATA_W-1:0] oe_seen;
  // Idle bus: strobes high, latch strobe high for straight-through addressing.
  initial
  begin
    {cs_b_out, rd_b_out, wr_b_out, ale_out} = 4'hf;
    addr_out = '0;
    dq_out = '0;
    oe_seen = '0;
  end
  // One access; select is low only while it lasts, released lines show inverted data.
  task automatic access(input logic wr, input logic mux, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd, output logic ok);
    int i;
    ok = 1'b0;
    rd = '0;
    @(posedge ref_clk_in);
    addr_out <= a;
    cs_b_out <= 1'b0;
    dq_out <= wd;
    if (mux)
    begin
      repeat (3) @(posedge ref_clk_in);
      ale_out <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      addr_out <= ~a;
      cs_b_out <= 1'b1;
    end
    repeat (3) @(posedge ref_clk_in);
    rd_b_out <= wr;
    wr_b_out <= !wr;
    for (i = 0; i < 8 && !ok; i++)
    begin
      @(posedge ref_clk_in);
      ok = wr ? (i == 3 && dq_oe_in == '0) : (dq_oe_in != '0);
      rd = dq_in & dq_oe_in;
      oe_seen = dq_oe_in;
    end
    rd_b_out <= 1'b1;
    wr_b_out <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    cs_b_out <= 1'b1;
    ale_out <= 1'b1;
    dq_out <= ~wd;
    repeat (2) @(posedge ref_clk_in);
  endtask
endmodule // ahp_host_model
`default_nettype wire

/* File: verification/ahp_host_port_bench.sv */
// Self-checking bench for the acquisition host bus port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_fail++; $display("unexpected %s exp %h seen %h", n, e, s); end end
module ahp_host_port_bench;
  import ahp_pkg::*;
  logic             ref_clk_in = 1'b0;
  logic             rst_b_in   = 1'b0;
  logic             bws        = 1'b0;
  logic             sync_drv   = 1'b0;
  logic             ok;
  logic [15:0]      rv;
  int               n_fail     = 0;
  int               n_checks   = 0;
  wire logic        cs_b, rd_b, wr_b, ale, sync_out, sync_oe, int_b, treq, diff;
  wire logic [4:0]  addr;
  wire logic [15:0] dq_h, dq_d, dq_oe;
  wire logic [2:0]  pos, neg;
  // The sync pin level comes from whoever drives it.
  wire logic        sync_pin = sync_oe ? sync_out : sync_drv;
  // 200 MHz clock.
  always #2.5 ref_clk_in = ~ref_clk_in;
  // Port under test and the host beside it.
  ahp_host_port ahp_host_port_i (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b), .rd_b_in(rd_b),
    .wr_b_in(wr_b), .ale_in(ale), .bus_width_select_in(bws), .register_select_lines_in(addr),
    .host_data_lines_in(dq_h), .host_data_lines_out(dq_d), .host_data_lines_oe_out(dq_oe), .sync_in(sync_pin),
    .sync_out(sync_out), .sync_oe_out(sync_oe), .conv_result_in(13'h1ffe), .aux_irq_in(4'h0), .mux_pos_out(pos),
    .mux_neg_out(neg), .mux_diff_out(diff), .int_b_out(int_b), .transfer_request_out(treq));
  ahp_host_model ahp_host_model_i (.ref_clk_in(ref_clk_in), .dq_in(dq_d), .dq_oe_in(dq_oe), .cs_b_out(cs_b),
    .rd_b_out(rd_b), .wr_b_out(wr_b), .ale_out(ale), .addr_out(addr), .dq_out(dq_h));
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Store and read cycles; a read also checks the drive enables during and after it.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    ahp_host_model_i.access(1'b1, 1'b0, a, d, rv, ok);
    `CHK("store done", 1'b1, ok)
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic m = 1'b0);
    ahp_host_model_i.access(1'b0, m, a, 16'h0000, rv, ok);
    `CHK("read done", 1'b1, ok)
    if (ok !== 1'b1) stop_test();
    `CHK("read data", e, rv)
    `CHK("drive enable", bws ? OE_BYTE : OE_WORD, ahp_host_model_i.oe_seen)
    `CHK("released enable", 16'h0000, dq_oe)
  endtask
  // Outputs right after reset.
  task automatic t_reset;
    `CHK("reset enable", 16'h0000, dq_oe)
    `CHK("reset sync dir", 1'b0, sync_oe)
    `CHK("reset int", 1'b1, int_b)
    `CHK("reset request", 1'b0, treq)
    $display("test reset done");
  endtask
  // Word and byte access to the instruction store, unmapped place, latched address.
  task automatic t_regs;
    wr(5'h00, 16'h0174);
    rd(5'h00, 16'h0174);
    rd(5'h16, 16'h0000);
    rd(5'h00, 16'h0174, 1'b1);
    `CHK("channel pos", 3'h5, pos)
    `CHK("channel neg", 3'h3, neg)
    `CHK("channel diff", 1'b1, diff)
    @(posedge ref_clk_in);
    bws <= 1'b1;
    rd(5'h00, 16'h0074);
    rd(5'h01, 16'h0001);
    wr(5'h02, 16'h0000);
    wr(5'h03, 16'h00ab);
    @(posedge ref_clk_in);
    bws <= 1'b0;
    rd(5'h02, 16'hab00);
    $display("test registers done");
  endtask
  // Repeated conversion with the sync pin as output, request, interrupt and their release.
  task automatic t_conv;
    int i;
    int n;
    wr(5'h12, 16'h0801);
    wr(5'h10, 16'h0081);
    `CHK("sync dir out", 1'b1, sync_oe)
    for (i = 0; i < 200 && sync_out !== 1'b1; i++) @(posedge ref_clk_in);
    for (n = 0; n < 200 && sync_out === 1'b1; n++) @(posedge ref_clk_in);
    `CHK("busy cycles", BUSY_CYCLES, 7'(n))
    if (n == 0 || n >= 200) stop_test();
    repeat (3) @(posedge ref_clk_in);
    `CHK("request on count", 1'b1, treq)
    `CHK("int pending", 1'b0, int_b)
    rd(5'h1e, 16'hfffe);
    `CHK("request after pop", 1'b0, treq)
    ahp_host_model_i.access(1'b0, 1'b0, 5'h14, 16'h0000, rv, ok);
    `CHK("done status", 1'b1, rv[IRQ_DONE])
    `CHK("int released", 1'b1, int_b)
    wr(5'h10, 16'h0002);
    $display("test conversion done");
  endtask
  // Sync pin as input: nothing starts until a rising edge on it.
  task automatic t_sync;
    wr(5'h10, 16'h0001);
    repeat (80) @(posedge ref_clk_in);
    `CHK("sync dir in", 1'b0, sync_oe)
    `CHK("no edge no result", 1'b0, treq)
    sync_drv <= 1'b1;
    repeat (80) @(posedge ref_clk_in);
    `CHK("edge gives result", 1'b1, treq)
    sync_drv <= 1'b0;
    $display("test sync input done");
  endtask
  // Main sequence.
  initial
  begin
    repeat (3) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    @(posedge ref_clk_in);
    t_reset();
    t_regs();
    t_conv();
    t_sync();
    stop_test();
  end
endmodule // ahp_host_port_bench
`default_nettype wire
